// ==== logic/pdss_sram.v ====
// pipelined synchronous static memory, 64K x 18, common data pins,
// two address strobes, 2-bit burst counter, double-cycle deselect
// assumes: all synchronous pins are stable around the rising clk_sys edge;
// output enable and sleep act without the clock
//
// Function
// - register every synchronous input on rising edge
// - 64K by 18 array, shared data pins
// - load address only on sampled strobe
// - accept address only when all enables active
// - low address bits seed the burst counter
// - burst addresses made inside, paced by advance
// - advance low increments counter once per edge
// - interleaved or linear burst order selectable
// - read data third clock, then every clock
// - inputs and read outputs both registered
// - writes captured then completed internally
// - per-lane active-low byte selects
// - lane selects need byte write enable low
// - global write enable writes all lanes
// - primary select high ignores processor strobe
// - drivers stay on one clock after deselect
// - output enable and sleep act asynchronously
// - both strobes low: processor strobe wins
// - output enable masked on first read clock
// - read data from previously registered address
// - sleep keeps data, pauses activity
`default_nettype none
`include "pdss_consts.vh"

module pdss_sram (
    input  wire                       clk_sys,
    input  wire                       arst_n,
    input  wire [`PDSS_AW-1:0]        addr,
    input  wire                       proc_addr_strobe_n,
    input  wire                       ctrl_addr_strobe_n,
    input  wire                       burst_advance_n,
    input  wire [`PDSS_LANES-1:0]     lane_write_sel_n,
    input  wire                       lane_write_enable_n,
    input  wire                       all_lanes_write_n,
    input  wire                       chip_sel_primary_n,
    input  wire                       chip_sel_expand_hi,
    input  wire                       chip_sel_expand_lo_n,
    input  wire                       burst_linear,
    input  wire                       out_enable_n,
    input  wire                       sleep_request,
    input  wire [`PDSS_DW-1:0]        dq_in,
    output wire [`PDSS_DW-1:0]        dq_out,
    output wire                       dq_oe_n
);

    // ************************************************************
    // array
    // ************************************************************
    reg [`PDSS_DW-1:0] mem_reg [0:`PDSS_DEPTH-1];

    // ************************************************************
    // state
    // ************************************************************
    reg [`PDSS_HI_W-1:0]  addr_hi_reg;
    reg [`PDSS_CNT_W-1:0] start_reg;
    reg [`PDSS_CNT_W-1:0] step_reg;
    reg                   linear_reg;
    reg                   selected_reg;
    reg                   rd_live_reg;
    reg                   out_valid_reg;
    reg                   hold_reg;
    reg                   desel_reg;
    reg [`PDSS_DW-1:0]    out_reg;
    reg                   wr_valid_reg;
    reg [`PDSS_AW-1:0]    wr_addr_reg;
    reg [`PDSS_DW-1:0]    wr_data_reg;
    reg [`PDSS_LANES-1:0] wr_lanes_reg;

    // ************************************************************
    // decode of the sampled pins
    // ************************************************************
    wire                   all_sel;
    wire                   proc_go;
    wire                   ctrl_go;
    wire                   load;
    wire [`PDSS_LANES-1:0] lanes_now;
    wire                   wr_req;
    wire [`PDSS_CNT_W-1:0] burst_lo;
    wire [`PDSS_AW-1:0]    cur_addr;
    wire [`PDSS_CNT_W-1:0] step_wr;
    wire [`PDSS_CNT_W-1:0] burst_wr;
    wire                   fifo_in_ready;
    wire                   fifo_out_valid;
    wire [`PDSS_WW-1:0]    fifo_out_data;
    wire                   stall;
    wire                   active;

    assign all_sel = ~chip_sel_primary_n & chip_sel_expand_hi
                   & ~chip_sel_expand_lo_n;
    // processor strobe is dead while primary select is high
    assign proc_go = ~proc_addr_strobe_n & ~chip_sel_primary_n;
    // controller strobe only counts when the processor one does not
    assign ctrl_go = ~ctrl_addr_strobe_n & ~proc_go;
    assign load    = proc_go | ctrl_go;

    // global write overrides the lane selects and their enable
    assign lanes_now = ~all_lanes_write_n ? `PDSS_ALL_LANES :
                       (~lane_write_enable_n ? ~lane_write_sel_n
                                             : `PDSS_ZERO_LANE);
    assign wr_req = (lanes_now != `PDSS_ZERO_LANE);

    // interleaved order is an xor of start and step
    assign burst_lo = linear_reg ? start_reg + step_reg
                                 : start_reg ^ step_reg;
    assign cur_addr = {addr_hi_reg, burst_lo};
    // a write beat with advance low lands on the advanced address,
    // the same one a read beat on that edge would fetch next
    assign step_wr  = burst_advance_n ? step_reg
                                      : step_reg + `PDSS_ONE_CNT;
    assign burst_wr = linear_reg ? start_reg + step_wr
                                 : start_reg ^ step_wr;

    // a full write buffer freezes capture rather than losing a beat
    assign stall  = wr_valid_reg & ~fifo_in_ready;
    // sleep freezes all synchronous activity, contents untouched
    assign active = ~sleep_request & ~stall;

    // ************************************************************
    // address, counter and select registers
    // ************************************************************
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            addr_hi_reg  <= {`PDSS_HI_W{1'b0}};
            start_reg    <= `PDSS_ZERO_CNT;
            step_reg     <= `PDSS_ZERO_CNT;
            linear_reg   <= 1'b0;
            selected_reg <= 1'b0;
            rd_live_reg  <= 1'b0;
            desel_reg    <= 1'b0;
        end else if (active) begin
            linear_reg <= burst_linear;
            if (load) begin
                selected_reg <= all_sel;
                desel_reg    <= ~all_sel;
                if (all_sel) begin
                    addr_hi_reg <= addr[`PDSS_AW-1:`PDSS_CNT_W];
                    start_reg   <= addr[`PDSS_CNT_W-1:0];
                    step_reg    <= `PDSS_ZERO_CNT;
                    // processor-strobe edges never write
                    rd_live_reg <= proc_go | ~wr_req;
                end else begin
                    rd_live_reg <= 1'b0;
                end
            end else if (selected_reg) begin
                desel_reg <= 1'b0;
                if (!burst_advance_n) begin
                    step_reg <= step_reg + `PDSS_ONE_CNT;
                end
                rd_live_reg <= ~wr_req;
            end else begin
                desel_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // write capture (self-timed: array update happens later)
    // ************************************************************
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_valid_reg <= 1'b0;
            wr_addr_reg  <= `PDSS_ZERO_ADDR;
            wr_data_reg  <= `PDSS_ZERO_DATA;
            wr_lanes_reg <= `PDSS_ZERO_LANE;
        end else if (active) begin
            wr_data_reg  <= dq_in;
            wr_lanes_reg <= lanes_now;
            if (load) begin
                wr_valid_reg <= ctrl_go & all_sel & wr_req;
                wr_addr_reg  <= addr;
            end else begin
                wr_valid_reg <= selected_reg & wr_req;
                wr_addr_reg  <= {addr_hi_reg, burst_wr};
            end
        end else if (!stall) begin
            // sleeping: nothing new is pushed
            wr_valid_reg <= 1'b0;
        end
    end

    // ************************************************************
    // write buffer and array update
    // ************************************************************
    pdss_fifo #(
        .WIDTH (`PDSS_WW),
        .DEPTH (`PDSS_FIFO_DEPTH),
        .AW    (`PDSS_FIFO_AW)
    ) u_wr_fifo (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_valid  (wr_valid_reg),
        .in_ready  (fifo_in_ready),
        .in_data   ({wr_lanes_reg, wr_addr_reg, wr_data_reg}),
        .out_valid (fifo_out_valid),
        .out_ready (~sleep_request),
        .out_data  (fifo_out_data)
    );

    // lanes written independently; drain pauses in sleep
    // one process owns the array so it has a single driver
    integer lane;
    always @(posedge clk_sys) begin
        for (lane = 0; lane < `PDSS_LANES; lane = lane + 1) begin
            if (fifo_out_valid && !sleep_request
                && fifo_out_data[`PDSS_WL_LSB + lane]) begin
                mem_reg[fifo_out_data[`PDSS_WA_MSB:`PDSS_WA_LSB]]
                    [lane*`PDSS_LANE_W +: `PDSS_LANE_W]
                    <= fifo_out_data[`PDSS_WD_LSB + lane*`PDSS_LANE_W
                                     +: `PDSS_LANE_W];
            end
        end
    end

    // ************************************************************
    // read pipeline and double-cycle deselect
    // ************************************************************
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_reg       <= `PDSS_ZERO_DATA;
            out_valid_reg <= 1'b0;
            hold_reg      <= 1'b0;
        end else if (active) begin
            if (rd_live_reg) begin
                // address registered on the previous edge
                out_reg <= mem_reg[cur_addr];
            end
            out_valid_reg <= rd_live_reg;
            // one extra driving clock when a deselect ended the read
            hold_reg <= out_valid_reg & ~rd_live_reg & desel_reg;
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    assign dq_out = out_reg;
    // drivers follow output enable and sleep with no clock in the way;
    // before the first valid read beat output enable has no effect
    assign dq_oe_n = ~((out_valid_reg | hold_reg)
                       & ~out_enable_n & ~sleep_request);

endmodule

`default_nettype wire

// ==== logic/pdss_consts.vh ====
// constants for the pipelined double-cycle-deselect synchronous memory
// assumes: included by bare name by the memory design file; the buffer module does not include it
`ifndef PDSS_CONSTS_VH
`define PDSS_CONSTS_VH

// ************************************************************
// array geometry
// ************************************************************
`define PDSS_AW        16
`define PDSS_DW        18
`define PDSS_DEPTH     65536
`define PDSS_LANES     2
`define PDSS_LANE_W    9
`define PDSS_CNT_W     2
`define PDSS_HI_W      14

// ************************************************************
// write word packing: {lane mask, address, data}
// ************************************************************
`define PDSS_WW        36
`define PDSS_WD_LSB    0
`define PDSS_WD_MSB    17
`define PDSS_WA_LSB    18
`define PDSS_WA_MSB    33
`define PDSS_WL_LSB    34
`define PDSS_WL_MSB    35

// ************************************************************
// reset values and buffer shape
// ************************************************************
`define PDSS_FIFO_DEPTH 4
`define PDSS_FIFO_AW    2
`define PDSS_ZERO_CNT   2'h0
`define PDSS_ONE_CNT    2'h1
`define PDSS_ZERO_ADDR  16'h0000
`define PDSS_ZERO_DATA  18'h00000
`define PDSS_ZERO_LANE  2'h0
`define PDSS_ALL_LANES  2'h3

`endif

// ==== logic/pdss_fifo.v ====
// small first-in first-out buffer with valid/ready on both sides
// assumes: one clock, asynchronous active-low reset; depth a power of two
`default_nettype none

module pdss_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_sys,
    input  wire             arst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    // ************************************************************
    // storage and pointers
    // ************************************************************
    reg [WIDTH-1:0] store_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = store_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            store_reg[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

// ==== verif/pdss_sram_checker.sv ====
// checker: pin-level timing of the pipelined memory
// assumes: bound to pdss_sram; one clock, reset active low
`default_nettype none
module pdss_sram_checker (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        proc_addr_strobe_n,
    input wire logic        ctrl_addr_strobe_n,
    input wire logic        burst_advance_n,
    input wire logic        lane_write_enable_n,
    input wire logic        all_lanes_write_n,
    input wire logic        chip_sel_primary_n,
    input wire logic        chip_sel_expand_hi,
    input wire logic        chip_sel_expand_lo_n,
    input wire logic        out_enable_n,
    input wire logic        sleep_request,
    input wire logic [17:0] dq_out,
    input wire logic        dq_oe_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    wire logic sel = !chip_sel_primary_n && chip_sel_expand_hi
                     && !chip_sel_expand_lo_n;
    wire logic ld = (!proc_addr_strobe_n && !chip_sel_primary_n)
                    || !ctrl_addr_strobe_n;
    wire logic wr = !all_lanes_write_n || !lane_write_enable_n;
    wire logic oe = !out_enable_n && !sleep_request;
    // driving, unless an async pin forbids it
    wire logic on = out_enable_n || sleep_request || !dq_oe_n;
    wire logic nostb = proc_addr_strobe_n && ctrl_addr_strobe_n;

    // ********
    // bus steps
    // ********
    sequence s_rd;
        !proc_addr_strobe_n && sel && !sleep_request;
    endsequence
    sequence s_beat;
        nostb && !burst_advance_n && !wr && oe;
    endsequence
    sequence s_dsel;
        ld && !sel && !sleep_request;
    endsequence
    sequence s_idle;
        nostb && !sleep_request;
    endsequence
    sequence s_ign;
        !proc_addr_strobe_n && chip_sel_primary_n && ctrl_addr_strobe_n
        && !burst_advance_n && !wr && oe;
    endsequence

    // ********
    // properties
    // ********
    AST_SLEEP_FLOAT: assert property (sleep_request |-> dq_oe_n)
        else $error("drivers on during sleep");
    AST_OE_FLOAT: assert property (out_enable_n |-> dq_oe_n)
        else $error("drivers on with output enable high");
    AST_READ_DRIVE: assert property (s_rd ##1 (!wr && !sleep_request)
        ##1 oe |-> !dq_oe_n) else $error("read data not driven on time");
    AST_BURST_DRIVE: assert property (s_rd ##1 s_beat[*3] |=> on)
        else $error("burst beat not driven");
    AST_PROC_IGNORED: assert property (s_rd ##1 s_ign ##1 s_beat[*2]
        |=> on) else $error("ignored strobe broke the burst");
    AST_DCD_HOLD: assert property (s_rd ##1 s_dsel ##1 !sleep_request
        ##1 oe |-> !dq_oe_n) else $error("drivers not held after deselect");
    AST_DCD_RELEASE: assert property (s_dsel ##1 s_idle[*3]
        |-> dq_oe_n) else $error("drivers still on after deselect");
    AST_OUT_HOLD: assert property (s_dsel ##1 s_idle[*3]
        |-> $stable(dq_out)) else $error("output register moved while idle");
endmodule

bind pdss_sram pdss_sram_checker i_pdss_sram_checker (
    .clk_sys, .arst_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
    .burst_advance_n, .lane_write_enable_n, .all_lanes_write_n,
    .chip_sel_primary_n, .chip_sel_expand_hi, .chip_sel_expand_lo_n,
    .out_enable_n, .sleep_request, .dq_out, .dq_oe_n
);
`default_nettype wire

// ==== verif/pdss_master.sv ====
// partner: bus master driving the memory's synchronous pins
// assumes: caller paces it, one clk_sys edge per drv call
`default_nettype none
module pdss_master (
    input  wire logic   clk_sys,
    output logic [15:0] addr,
    output logic        proc_addr_strobe_n,
    output logic        ctrl_addr_strobe_n,
    output logic        burst_advance_n,
    output logic [1:0]  lane_write_sel_n,
    output logic        lane_write_enable_n,
    output logic        all_lanes_write_n,
    output logic        chip_sel_primary_n,
    output logic        chip_sel_expand_hi,
    output logic        chip_sel_expand_lo_n,
    output logic [17:0] dq_in
);
    initial begin
        {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
        {lane_write_enable_n, all_lanes_write_n} = 2'h3;
        {chip_sel_primary_n, chip_sel_expand_hi} = 2'h2;
        chip_sel_expand_lo_n = 1'b0;
        lane_write_sel_n = 2'h3;
        addr = 16'h0000;
        dq_in = 18'h00000;
    end
    // c = {proc strobe, ctrl strobe, advance, global write, byte write}
    task automatic drv(input logic [4:0] c, input logic [1:0] ln,
                       input logic [1:0] ce, input logic [15:0] a,
                       input logic [17:0] d);
        @(posedge clk_sys);
        proc_addr_strobe_n <= c[4];
        ctrl_addr_strobe_n <= c[3];
        burst_advance_n <= c[2];
        all_lanes_write_n <= c[1];
        lane_write_enable_n <= c[0];
        lane_write_sel_n <= ln;
        {chip_sel_primary_n, chip_sel_expand_hi} <= ce;
        addr <= a;
        // released data lines never keep the last value
        dq_in <= (c[1:0] != 2'h3) ? d : ~dq_in;
    endtask
endmodule
`default_nettype wire

// ==== verif/pdss_sram_test.sv ====
// testbench: memory driven through the bus master model
// assumes: design, master and checker compiled before this file
`default_nettype none
module pdss_sram_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys;
    logic        arst_n;
    logic        burst_linear;
    logic        out_enable_n;
    logic        sleep_request;
    wire  [15:0] addr;
    wire  [1:0]  lane_write_sel_n;
    wire  [17:0] dq_in, dq_out;
    wire         proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
    wire         lane_write_enable_n, all_lanes_write_n, dq_oe_n;
    wire         chip_sel_primary_n, chip_sel_expand_hi, chip_sel_expand_lo_n;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    logic [17:0] shadow [logic [15:0]];

    pdss_sram i_pdss_sram (.clk_sys, .arst_n, .addr, .proc_addr_strobe_n,
        .ctrl_addr_strobe_n, .burst_advance_n, .lane_write_sel_n,
        .lane_write_enable_n, .all_lanes_write_n, .chip_sel_primary_n,
        .chip_sel_expand_hi, .chip_sel_expand_lo_n, .burst_linear,
        .out_enable_n, .sleep_request, .dq_in, .dq_out, .dq_oe_n);
    pdss_master i_pdss_master (.clk_sys, .addr, .proc_addr_strobe_n,
        .ctrl_addr_strobe_n, .burst_advance_n, .lane_write_sel_n,
        .lane_write_enable_n, .all_lanes_write_n, .chip_sel_primary_n,
        .chip_sel_expand_hi, .chip_sel_expand_lo_n, .dq_in);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // whole run is about a hundred cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] baddr(input logic [15:0] a, input int k);
        logic [1:0] s;
        s = burst_linear ? a[1:0] + k[1:0] : a[1:0] ^ k[1:0];
        return {a[15:2], s};
    endfunction

    task automatic idle(input int n);
        repeat (n) i_pdss_master.drv(5'h1f, 2'h3, 2'h1, 16'h0, 18'h0);
    endtask

    // ********
    // scenarios
    // ********
    task automatic wr_burst(input logic [15:0] a, input logic [17:0] d);
        for (int k = 0; k < 4; k++) begin
            i_pdss_master.drv(k == 0 ? 5'h15 : 5'h19, 2'h3, 2'h1, a, d + 18'(k));
            shadow[baddr(a, k)] = d + 18'(k);
        end
        idle(4);  // array write lags capture by a few edges
    endtask

    task automatic rd_burst(input logic [15:0] a, input int n,
                            input logic ign, input logic fresh);
        logic [4:0] c;
        for (int i = 0; i <= n + 1; i++) begin
            c = i == 0 ? 5'h0f : i >= n ? 5'h1f : ign && i == 1 ? 5'h0b : 5'h1b;
            i_pdss_master.drv(c, 2'h3, (ign && i == 1) ? 2'h3 : 2'h1,
                              i == 0 ? a : a ^ 16'h0100, 18'h0);
            #1;
            if (fresh && i == 1) check(dq_oe_n, 18'h1);
            if (i >= 2) begin
                check(dq_out, shadow[baddr(a, i - 2)]);
                check(dq_oe_n, 18'h0);
            end
        end
    endtask

    task automatic t_lanes(input logic [15:0] a);
        i_pdss_master.drv(5'h16, 2'h2, 2'h1, a, 18'h2aaaa);
        shadow[a][8:0] = 9'h0aa;
        i_pdss_master.drv(5'h17, 2'h0, 2'h1, a + 16'h1, 18'h15555);
        i_pdss_master.drv(5'h16, 2'h1, 2'h1, a + 16'h2, 18'h15555);
        shadow[a + 16'h2][17:9] = 9'h0aa;
        idle(4);
        rd_burst(a, 3, 1'b0, 1'b0);
    endtask

    task automatic t_both(input logic [15:0] a);
        i_pdss_master.drv(5'h05, 2'h3, 2'h1, a, 18'h3ffff);
        idle(2);
        #1;
        check(dq_out, shadow[a]);
        idle(3);
        rd_burst(a, 1, 1'b0, 1'b0);
    endtask

    task automatic t_dcd(input logic [15:0] a);
        i_pdss_master.drv(5'h0f, 2'h3, 2'h1, a, 18'h0);
        i_pdss_master.drv(5'h17, 2'h3, 2'h0, a, 18'h0);
        for (int i = 0; i < 3; i++) begin
            idle(1);
            #1;
            check(dq_oe_n, 18'(i == 2));
        end
        check(dq_out, shadow[a]);
        idle(2);
        rd_burst(a, 2, 1'b0, 1'b1);
    endtask

    task automatic t_async(input logic [15:0] a);
        i_pdss_master.drv(5'h0f, 2'h3, 2'h1, a, 18'h0);
        idle(2);
        out_enable_n <= 1'b1;
        #1;
        check(dq_oe_n, 18'h1);
        idle(1);
        out_enable_n <= 1'b0;
        sleep_request <= 1'b1;
        #1;
        check(dq_oe_n, 18'h1);
        idle(4);
        sleep_request <= 1'b0;
        idle(3);
        rd_burst(a, 1, 1'b0, 1'b0);
    endtask

    initial begin
        arst_n = 1'b0;
        burst_linear = 1'b1;
        out_enable_n = 1'b0;
        sleep_request = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        check(dq_oe_n, 18'h1);
        check(dq_out, 18'h0);
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        wr_burst(16'h0041, 18'h00100);
        rd_burst(16'h0041, 4, 1'b0, 1'b0);
        burst_linear <= 1'b0;
        wr_burst(16'h0086, 18'h00200);
        rd_burst(16'h0086, 4, 1'b0, 1'b0);
        rd_burst(16'h0041, 4, 1'b1, 1'b0);
        burst_linear <= 1'b1;
        t_lanes(16'h0040);
        t_both(16'h0084);
        t_dcd(16'h0085);
        t_async(16'h0087);
        end_of_test();
    end
endmodule
`default_nettype wire
